// *** rtl/cise_pkg.sv ***
// cise_pkg: shared constants and types for the instruction subset executor
`default_nettype none
package cise_pkg;
	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int IP_W   = 11;
	localparam int DATA_W = 8;
	localparam int FADR_W = 5;
	localparam int LIT_W  = 9;

	// ---------------------------------------------------------------
	// constant values
	// ---------------------------------------------------------------
	localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE     = 8'h01;
	localparam logic [IP_W-1:0]   IP_STEP      = 11'h001;
	localparam logic [IP_W-1:0]   IP_RESET     = 11'h000;
	localparam logic [FADR_W-1:0] FADR_RESET   = 5'h00;
	localparam logic              ZERO_RESET   = 1'b0;
	localparam logic              ACTIVE_N_OFF = 1'b1;
	localparam logic              DEST_ACC     = 1'b0;
	localparam logic              DEST_FILE    = 1'b1;
	localparam logic              PAGE8_CALL   = 1'b0;

	// ---------------------------------------------------------------
	// operations and states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP,
		OP_ACCUMULATOR_CLEAR,
		OP_CALL,
		OP_WATCHDOG_KICK,
		OP_FILE_ZEROING,
		OP_FILE_INVERT,
		OP_FILE_MINUS_ONE,
		OP_FILE_MINUS_ONE_SKIP,
		OP_BRANCH_ABSOLUTE
	} cise_op_t;

	typedef enum logic [1:0] {
		ST_ISSUE,
		ST_REFILL,
		ST_SKIP
	} cise_state_t;

	typedef struct packed {
		cise_op_t          op;
		logic [FADR_W-1:0] faddr;
		logic              dest;
		logic [LIT_W-1:0]  literal;
	} cise_instr_t;

	typedef struct packed {
		logic              we;
		logic [FADR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cise_fwrite_t;
endpackage : cise_pkg
`default_nettype wire

// *** rtl/cise_core.sv ***
// cise_core: executes accumulator, file, watchdog, call and branch instructions
`default_nettype none
module cise_core
	import cise_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                rstn,
	// instruction issue
	input  wire logic                instr_valid,
	input  wire cise_instr_t         instr,
	output logic                     instr_ready,
	// file register read port, combinational on instr.faddr
	output logic [FADR_W-1:0]        file_raddr,
	input  wire logic [DATA_W-1:0]   file_rdata,
	// file register write port
	output cise_fwrite_t             file_write,
	// status inputs
	input  wire logic [1:0]          status_page,
	input  wire logic                prescaler_to_watchdog,
	input  wire logic                watchdog_timeout,
	input  wire logic                sleep_enter,
	// return stack
	output logic                     stack_push,
	output logic [IP_W-1:0]          stack_data,
	// watchdog control
	output logic                     watchdog_count_clear,
	output logic                     prescaler_clear,
	// architectural state
	output logic [DATA_W-1:0]        accumulator,
	output logic                     zero_flag,
	output logic                     watchdog_expired_n,
	output logic                     sleep_entered_n,
	output logic [IP_W-1:0]          instruction_pointer
);
	// ---------------------------------------------------------------
	// next-state signals
	// ---------------------------------------------------------------
	cise_state_t       state;
	cise_state_t       next_state;
	logic [DATA_W-1:0] next_accumulator;
	logic              next_zero_flag;
	logic              next_watchdog_expired_n;
	logic              next_sleep_entered_n;
	logic [IP_W-1:0]   next_instruction_pointer;
	cise_fwrite_t      next_file_write;
	logic              next_stack_push;
	logic [IP_W-1:0]   next_stack_data;
	logic              next_watchdog_count_clear;
	logic              next_prescaler_clear;
	logic              issue;
	logic [DATA_W-1:0] result;
	logic [IP_W-1:0]   ip_plus_one;

	assign instr_ready = (state == ST_ISSUE);
	assign issue       = instr_valid && instr_ready;
	assign file_raddr  = instr.faddr;
	assign ip_plus_one = instruction_pointer + IP_STEP;

	// ---------------------------------------------------------------
	// execute
	// ---------------------------------------------------------------
	always_comb begin
		next_state                = state;
		next_accumulator          = accumulator;
		next_zero_flag            = zero_flag;
		next_instruction_pointer  = instruction_pointer;
		next_file_write           = '{we: 1'b0, addr: instr.faddr, data: ZERO_BYTE};
		next_stack_push           = 1'b0;
		next_stack_data           = stack_data;
		next_watchdog_count_clear = 1'b0;
		next_prescaler_clear      = 1'b0;
		next_watchdog_expired_n   = watchdog_expired_n;
		next_sleep_entered_n      = sleep_entered_n;
		result                    = ZERO_BYTE;
		// other parties may pull the active-low bits; a kick below wins
		if (watchdog_timeout) begin
			next_watchdog_expired_n = 1'b0;
		end
		if (sleep_enter) begin
			next_sleep_entered_n = 1'b0;
		end
		case (state)
			ST_ISSUE: begin
				if (issue) begin
					next_instruction_pointer = ip_plus_one;
					case (instr.op)
						OP_ACCUMULATOR_CLEAR: begin
							next_accumulator = ZERO_BYTE;
							next_zero_flag   = 1'b1;
						end
						OP_CALL: begin
							next_stack_push = 1'b1;
							next_stack_data = ip_plus_one;
							next_instruction_pointer = {status_page, PAGE8_CALL,
								instr.literal[DATA_W-1:0]};
							next_state = ST_REFILL;
						end
						OP_WATCHDOG_KICK: begin
							next_watchdog_count_clear = 1'b1;
							next_prescaler_clear = prescaler_to_watchdog;
							next_watchdog_expired_n = 1'b1;
							next_sleep_entered_n    = 1'b1;
						end
						OP_FILE_ZEROING: begin
							next_file_write.we   = 1'b1;
							next_file_write.data = ZERO_BYTE;
							next_zero_flag       = 1'b1;
						end
						OP_FILE_INVERT, OP_FILE_MINUS_ONE, OP_FILE_MINUS_ONE_SKIP: begin
							if (instr.op == OP_FILE_INVERT) begin
								result = ~file_rdata;
							end else begin
								result = file_rdata - ONE_BYTE;
							end
							if (instr.dest == DEST_FILE) begin
								next_file_write.we   = 1'b1;
								next_file_write.data = result;
							end else begin
								next_accumulator = result;
							end
							if (instr.op != OP_FILE_MINUS_ONE_SKIP) begin
								next_zero_flag = (result == ZERO_BYTE);
							end else if (result == ZERO_BYTE) begin
								next_state = ST_SKIP;
							end
						end
						OP_BRANCH_ABSOLUTE: begin
							next_instruction_pointer = {status_page, instr.literal};
							next_state = ST_REFILL;
						end
						default: begin
						end
					endcase
				end
			end
			ST_REFILL: begin
				next_state = ST_ISSUE;
			end
			ST_SKIP: begin
				// the discarded instruction runs as a no-op; step over it
				next_instruction_pointer = ip_plus_one;
				next_state               = ST_ISSUE;
			end
			default: begin
				next_state = ST_ISSUE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state                <= ST_ISSUE;
			accumulator          <= ZERO_BYTE;
			zero_flag            <= ZERO_RESET;
			watchdog_expired_n   <= ACTIVE_N_OFF;
			sleep_entered_n      <= ACTIVE_N_OFF;
			instruction_pointer  <= IP_RESET;
			file_write           <= '{we: 1'b0, addr: FADR_RESET, data: ZERO_BYTE};
			stack_push           <= 1'b0;
			stack_data           <= IP_RESET;
			watchdog_count_clear <= 1'b0;
			prescaler_clear      <= 1'b0;
		end else begin
			state                <= next_state;
			accumulator          <= next_accumulator;
			zero_flag            <= next_zero_flag;
			watchdog_expired_n   <= next_watchdog_expired_n;
			sleep_entered_n      <= next_sleep_entered_n;
			instruction_pointer  <= next_instruction_pointer;
			file_write           <= next_file_write;
			stack_push           <= next_stack_push;
			stack_data           <= next_stack_data;
			watchdog_count_clear <= next_watchdog_count_clear;
			prescaler_clear      <= next_prescaler_clear;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	logic is_call;
	logic is_kick;
	logic is_dec;
	logic is_skip;
	logic is_branch_absolute;
	assign is_call = issue && (instr.op == OP_CALL);
	assign is_kick = issue && (instr.op == OP_WATCHDOG_KICK);
	assign is_dec  = issue && (instr.op == OP_FILE_MINUS_ONE);
	assign is_skip = issue && (instr.op == OP_FILE_MINUS_ONE_SKIP);
	assign is_branch_absolute = issue && (instr.op == OP_BRANCH_ABSOLUTE);

	a_acc_clear: assert property (
		issue && instr.op == OP_ACCUMULATOR_CLEAR
		|=> accumulator == ZERO_BYTE && zero_flag)
		else $error("accumulator clear wrong");
	a_call_push: assert property (
		is_call
		|=> stack_push && stack_data == $past(instruction_pointer) + IP_STEP)
		else $error("call return address wrong");
	a_call_low: assert property (
		is_call
		|=> instruction_pointer[7:0] == $past(instr.literal[7:0]))
		else $error("call low bits wrong");
	a_call_page: assert property (
		is_call
		|=> instruction_pointer[10:9] == $past(status_page) && !instruction_pointer[8])
		else $error("call page bits wrong");
	a_call_cycles: assert property (
		is_call
		|=> !instr_ready && $stable(zero_flag) ##1 instr_ready)
		else $error("call timing or flags wrong");
	a_kick_count: assert property (is_kick |=> watchdog_count_clear)
		else $error("watchdog count not cleared");
	a_kick_prescale: assert property (
		is_kick
		|=> prescaler_clear == $past(prescaler_to_watchdog))
		else $error("prescaler clear wrong");
	a_kick_bits: assert property (is_kick |=> watchdog_expired_n && sleep_entered_n)
		else $error("status bits not set");
	a_file_zero: assert property (
		issue && instr.op == OP_FILE_ZEROING
		|=> file_write.we && file_write.data == ZERO_BYTE && zero_flag)
		else $error("file zeroing wrong");
	a_invert_val: assert property (
		issue && instr.op == OP_FILE_INVERT && instr.dest == DEST_FILE
		|=> file_write.data == ~$past(file_rdata)
		&& zero_flag == (file_write.data == ZERO_BYTE))
		else $error("invert result wrong");
	a_dest_acc: assert property (
		issue && instr.dest == DEST_ACC
		&& (instr.op == OP_FILE_INVERT || instr.op == OP_FILE_MINUS_ONE)
		|=> !file_write.we && accumulator == ($past(instr.op) == OP_FILE_INVERT
		? ~$past(file_rdata) : $past(file_rdata) - ONE_BYTE))
		else $error("destination zero wrote the file");
	a_dec_flag: assert property (
		is_dec && instr.dest == DEST_ACC
		|=> accumulator == $past(file_rdata) - ONE_BYTE
		&& zero_flag == (accumulator == ZERO_BYTE))
		else $error("decrement result wrong");
	a_skip_taken: assert property (
		is_skip && file_rdata == ONE_BYTE
		|=> !instr_ready && $stable(zero_flag) ##1 instr_ready
		&& instruction_pointer == $past(instruction_pointer, 2) + 11'h002)
		else $error("skip not taken");
	a_branch_absolute_target: assert property (
		is_branch_absolute
		|=> instruction_pointer == {$past(status_page), $past(instr.literal)})
		else $error("branch target wrong");
	a_branch_absolute_cycles: assert property (
		is_branch_absolute
		|=> !instr_ready && $stable(zero_flag) ##1 instr_ready)
		else $error("branch timing or flags wrong");
	a_refill_hold: assert property (
		state == ST_REFILL
		|=> $stable(instruction_pointer) && $stable(zero_flag))
		else $error("refill cycle moved pointer or flag");
	a_dec_wrap: assert property (
		is_dec && instr.dest == DEST_ACC && file_rdata == ZERO_BYTE
		|=> accumulator == 8'hFF && !zero_flag)
		else $error("decrement did not wrap");

	c_call: cover property (is_call ##2 issue);
	c_skip: cover property (is_skip && file_rdata == ONE_BYTE);
	c_kick: cover property (is_kick && prescaler_to_watchdog);
	c_branch_absolute: cover property (is_branch_absolute);
	c_kick_clash: cover property (is_kick && watchdog_timeout && sleep_enter);
endmodule : cise_core
`default_nettype wire

// *** tb/test_cpu_instr_subset_exec.sv ***
// test_cpu_instr_subset_exec: self-checking bench for the instruction subset executor
`default_nettype none
module test_cpu_instr_subset_exec
	import cise_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ---------------------------------------------------------------
	// signals and file register model
	// ---------------------------------------------------------------
	logic                core_clk, rstn, instr_valid, instr_ready, stack_push;
	logic                prescaler_to_watchdog, watchdog_timeout, sleep_enter;
	logic                watchdog_count_clear, prescaler_clear, zero_flag;
	logic                watchdog_expired_n, sleep_entered_n;
	cise_instr_t         instr;
	cise_fwrite_t        file_write;
	logic [FADR_W-1:0]   file_raddr;
	logic [DATA_W-1:0]   file_rdata, accumulator;
	logic [1:0]          status_page;
	logic [IP_W-1:0]     stack_data, instruction_pointer, ip_e, ret;
	logic [DATA_W-1:0]   fmem [32];
	int                  n_fail, n_compared;

	// combinational read, as the core expects
	assign file_rdata = fmem[file_raddr];
	always @(posedge core_clk) begin
		if (file_write.we === 1'b1) begin
			fmem[file_write.addr] <= file_write.data;
		end
	end

	cise_core i_dut (
		.core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .file_raddr(file_raddr), .file_rdata(file_rdata),
		.file_write(file_write), .status_page(status_page),
		.prescaler_to_watchdog(prescaler_to_watchdog), .watchdog_timeout(watchdog_timeout),
		.sleep_enter(sleep_enter), .stack_push(stack_push), .stack_data(stack_data),
		.watchdog_count_clear(watchdog_count_clear), .prescaler_clear(prescaler_clear),
		.accumulator(accumulator), .zero_flag(zero_flag),
		.watchdog_expired_n(watchdog_expired_n), .sleep_entered_n(sleep_entered_n),
		.instruction_pointer(instruction_pointer)
	);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask : tick

	// valid stays up afterwards so the next call runs back to back
	task automatic issue(input cise_op_t op, input logic [4:0] fa, input logic d,
		input logic [8:0] k);
		int n;
		instr = '{op, fa, d, k};
		instr_valid = 1'b1;
		n = 0;
		while (instr_ready !== 1'b1 && n < 10) begin
			tick();
			n++;
		end
		if (n == 10) begin
			n_fail++;
			$display("Error at %0t: instruction never accepted", $time);
			final_report();
		end
		if (op == OP_CALL) begin
			ip_e = {status_page, 1'b0, k[7:0]};
		end else if (op == OP_BRANCH_ABSOLUTE) begin
			ip_e = {status_page, k};
		end else begin
			ip_e = ip_e + IP_STEP;
		end
		tick();
		chk(16'(instruction_pointer), 16'(ip_e), "pointer");
	endtask : issue

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		instr_valid = 1'b0;
		instr = '0;
		status_page = 2'h0;
		prescaler_to_watchdog = 1'b0;
		watchdog_timeout = 1'b0;
		sleep_enter = 1'b0;
		n_fail = 0;
		n_compared = 0;
		ip_e = IP_RESET;
		for (int i = 0; i < 32; i++) begin
			fmem[i] = 8'h00;
		end
		repeat (4) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		chk(16'(accumulator), 16'h0000, "acc after reset");
		chk(16'({watchdog_expired_n, sleep_entered_n, zero_flag}), 16'h0006, "flags reset");
		chk(16'(instruction_pointer), 16'(IP_RESET), "pointer reset");
		$display("test reset done");

		fmem[2] = 8'h5A;
		fmem[5] = 8'h01;
		fmem[6] = 8'hA5;
		fmem[8] = 8'h01;
		fmem[7] = 8'h02;
		issue(OP_FILE_INVERT, 5'h02, DEST_ACC, 9'h000);
		chk(16'({file_write.we, zero_flag, accumulator}), 16'h00A5, "invert to acc");
		issue(OP_ACCUMULATOR_CLEAR, 5'h00, DEST_ACC, 9'h000);
		chk(16'({zero_flag, accumulator}), 16'h0100, "acc clear");
		issue(OP_FILE_INVERT, 5'h03, DEST_FILE, 9'h000);
		chk(16'(file_write), 16'({1'b1, 5'h03, 8'hFF}), "invert to file");
		chk(16'(zero_flag), 16'h0000, "invert zero flag");
		issue(OP_FILE_MINUS_ONE, 5'h04, DEST_FILE, 9'h000);
		chk(16'(file_write), 16'({1'b1, 5'h04, 8'hFF}), "wrap to file");
		chk(16'(zero_flag), 16'h0000, "wrap zero flag");
		issue(OP_FILE_MINUS_ONE, 5'h05, DEST_ACC, 9'h000);
		chk(16'({file_write.we, zero_flag, accumulator}), 16'h0100, "minus one to acc");
		issue(OP_FILE_MINUS_ONE, 5'h09, DEST_ACC, 9'h000);
		chk(16'({file_write.we, zero_flag, accumulator}), 16'h00FF, "wrap to acc");
		issue(OP_FILE_MINUS_ONE, 5'h06, DEST_ACC, 9'h000);
		chk(16'({zero_flag, accumulator}), 16'h00A4, "minus one value");
		issue(OP_FILE_ZEROING, 5'h06, DEST_ACC, 9'h000);
		chk(16'(file_write), 16'({1'b1, 5'h06, 8'h00}), "zeroing write");
		chk(16'({zero_flag, accumulator}), 16'h01A4, "zeroing flag");
		$display("test file ops done");

		issue(OP_FILE_MINUS_ONE_SKIP, 5'h07, DEST_FILE, 9'h000);
		chk(16'(file_write), 16'({1'b1, 5'h07, 8'h01}), "no-skip write");
		chk(16'({instr_ready, zero_flag}), 16'h0003, "no skip, flag kept");
		issue(OP_FILE_MINUS_ONE_SKIP, 5'h08, DEST_ACC, 9'h000);
		chk(16'({instr_ready, zero_flag, accumulator}), 16'h0100, "skip cycle");
		tick();
		ip_e = ip_e + IP_STEP;
		chk(16'({instr_ready, instruction_pointer}), 16'({1'b1, ip_e}), "skip step");
		$display("test skip done");

		status_page = 2'h2;
		ret = ip_e + IP_STEP;
		issue(OP_CALL, 5'h00, 1'b0, 9'h1A5);
		chk(16'(instruction_pointer), 16'h04A5, "call target");
		chk(16'({stack_push, stack_data}), 16'({1'b1, ret}), "return push");
		chk(16'({instr_ready, zero_flag}), 16'h0001, "call cycles");
		status_page = 2'h1;
		issue(OP_BRANCH_ABSOLUTE, 5'h00, 1'b0, 9'h1FF);
		chk(16'(instruction_pointer), 16'h03FF, "branch target");
		chk(16'({instr_ready, stack_push, zero_flag}), 16'h0001, "branch cycles");
		issue(OP_NOP, 5'h00, 1'b0, 9'h000);
		chk(16'({instr_ready, file_write.we, zero_flag}), 16'h0005, "no-op keeps state");
		$display("test call and branch done");

		for (int p = 0; p < 2; p++) begin
			instr_valid = 1'b0;
			watchdog_timeout = 1'b1;
			sleep_enter = 1'b1;
			tick();
			watchdog_timeout = 1'b0;
			sleep_enter = 1'b0;
			tick();
			chk(16'({watchdog_expired_n, sleep_entered_n}), 16'h0000, "status cleared");
			prescaler_to_watchdog = 1'(p);
			issue(OP_WATCHDOG_KICK, 5'h00, 1'b0, 9'h000);
			chk(16'(watchdog_count_clear), 16'h0001, "count clear");
			chk(16'(prescaler_clear), 16'(p), "prescaler clear");
			chk(16'({watchdog_expired_n, sleep_entered_n}), 16'h0003, "status set");
		end
		instr_valid = 1'b0;
		tick();
		chk(16'({watchdog_count_clear, prescaler_clear}), 16'h0000, "clear pulse ends");
		// a kick in the same cycle as timeout and sleep entry must win
		watchdog_timeout = 1'b1;
		sleep_enter = 1'b1;
		issue(OP_WATCHDOG_KICK, 5'h00, 1'b0, 9'h000);
		watchdog_timeout = 1'b0;
		sleep_enter = 1'b0;
		instr_valid = 1'b0;
		chk(16'({watchdog_expired_n, sleep_entered_n}), 16'h0003, "kick wins");
		$display("test watchdog done");
		final_report();
	end
endmodule : test_cpu_instr_subset_exec
`default_nettype wire
